// ---- bench/asre_checker.sv ----
// Purpose: Port-level assertions for the serial receiver
// Assumes: One clock, synchronous active-low reset
// Notes:   Mirrors the enables from completed writes, not from the bodies
`timescale 1ns/1ps
`include "asre_map.vh"
module asre_checker (
  input wire        aclk,          // Clock
  input wire        aresetn,       // Reset
  input wire        rx_pin,        // Line
  input wire        irq,           // Interrupt
  input wire [4:0]  s_axi_awaddr,  // AW
  input wire        s_axi_awvalid, // AW
  input wire        s_axi_awready, // AW
  input wire [31:0] s_axi_wdata,   // W
  input wire [3:0]  s_axi_wstrb,   // W
  input wire        s_axi_wvalid,  // W
  input wire        s_axi_wready,  // W
  input wire [1:0]  s_axi_bresp,   // B
  input wire        s_axi_bvalid,  // B
  input wire        s_axi_bready,  // B
  input wire [4:0]  s_axi_araddr,  // AR
  input wire        s_axi_arvalid, // AR
  input wire        s_axi_arready, // AR
  input wire [31:0] s_axi_rdata,   // R
  input wire [1:0]  s_axi_rresp,   // R
  input wire        s_axi_rvalid,  // R
  input wire        s_axi_rready   // R
);
  reg        aw_got_ff, w_got_ff, serial_port_enable_off_ff;
  reg [4:0]  waddr_ff, raddr_ff;
  reg [31:0] wdat_ff;
  reg [3:0]  wstb_ff;
  reg [1:0]  ien_ff;
  wire       aw_now  = s_axi_awvalid && s_axi_awready;
  wire       w_now   = s_axi_wvalid && s_axi_wready;
  wire       wr_done = (aw_now || aw_got_ff) && (w_now || w_got_ff);
  wire [4:0] wa      = aw_now ? s_axi_awaddr : waddr_ff;
  wire [7:0] wd      = w_now ? s_axi_wdata[7:0] : wdat_ff[7:0];
  wire       ws      = w_now ? s_axi_wstrb[0] : wstb_ff[0];
  // Address and data may be taken on different edges
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff   <= 1'b0;
      w_got_ff    <= 1'b0;
      serial_port_enable_off_ff <= 1'b1;
      ien_ff      <= 2'h0;
    end else begin
      aw_got_ff <= (aw_now || aw_got_ff) && !wr_done;
      w_got_ff  <= (w_now || w_got_ff) && !wr_done;
      if (aw_now) waddr_ff <= s_axi_awaddr;
      if (w_now) wdat_ff <= s_axi_wdata;
      if (w_now) wstb_ff <= s_axi_wstrb;
      if (s_axi_arvalid && s_axi_arready) raddr_ff <= s_axi_araddr;
      if (wr_done && ws && wa == `ASRE_OFF_CTRL) serial_port_enable_off_ff <= !wd[0];
      if (wr_done && ws && wa == `ASRE_OFF_IEN) ien_ff <= wd[1:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_resp_stable: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_stable: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (wr_done |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_unmapped_err: assert property (s_axi_rvalid && raddr_ff >= 5'h1C |->
    s_axi_rresp == `ASRE_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_unit_reset: assert property (
    s_axi_rvalid && raddr_ff == `ASRE_OFF_STAT && serial_port_enable_off_ff |-> s_axi_rdata[4:0] == 5'h00)
    else $error("status not cleared by port disable");
  a_irq_enabled: assert property (irq |-> ien_ff != 2'h0)
    else $error("interrupt without enable");
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !irq) else $error("outputs busy after reset");
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `ASRE_RESP_SLVERR);
  c_irq_rise: cover property ($rose(irq));
  c_overrun: cover property (s_axi_rvalid && raddr_ff == `ASRE_OFF_STAT && s_axi_rdata[1]);
endmodule // asre_checker

bind asre_top asre_checker asre_checker_i (.aclk, .aresetn, .rx_pin, .irq, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- bench/asre_tb.sv ----
// Purpose: Self-checking bench for the serial receiver
// Assumes: Divisor 1, so one bit lasts 32 clocks
// Notes:   Status is always read before data, as software must
`timescale 1ns/1ps
`include "asre_map.vh"
module testbench;
  localparam BIT_CLKS = 16 * (1 + 1);
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [4:0]  aw = 5'h00, ar = 5'h00;
  reg  [31:0] wd = 32'h0000_0000;
  reg         awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire        line, irq, awr, wr, bv, arr, rv;
  wire [1:0]  br, rr;
  wire [31:0] rd;
  integer     miscompares = 0, num_checks = 0;
  always #50 aclk = ~aclk;
  asre_top asre_top_i (.aclk(aclk), .aresetn(aresetn), .rx_pin(line), .irq(irq),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  asre_tx_model #(.BIT_CLKS(BIT_CLKS)) asre_tx_model_i (.aclk(aclk), .line(line));
  task automatic give_verdict;
    begin
      if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input [11:0] e, input [11:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Handshakes are judged on settled values before the edge that takes them
  task automatic axi_wr(input [4:0] a, input [11:0] d);
    integer n;
    reg     aw_hit, w_hit, b_hit;
    begin
      @(posedge aclk);
      aw <= a;
      wd <= {20'h0_0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      n = 0;
      do begin
        @(negedge aclk);
        aw_hit = awv && awr;
        w_hit = wv && wr;
        b_hit = bv;
        @(posedge aclk);
        n = n + 1;
        if (aw_hit) awv <= 1'b0;
        if (w_hit) wv <= 1'b0;
      end while (!b_hit && n < 50);
      bry <= 1'b0;
      chk("write_done", 12'h001, {11'h000, b_hit});
    end
  endtask
  task automatic axi_rd(input [4:0] a, output [31:0] d);
    integer n;
    reg     ar_hit, r_hit;
    begin
      @(posedge aclk);
      ar <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      n = 0;
      d = 32'h0000_0000;
      do begin
        @(negedge aclk);
        ar_hit = arv && arr;
        r_hit = rv;
        d = rd;
        @(posedge aclk);
        n = n + 1;
        if (ar_hit) arv <= 1'b0;
      end while (!r_hit && n < 50);
      rry <= 1'b0;
      chk("read_done", 12'h001, {11'h000, r_hit});
    end
  endtask
  task automatic chk_rd(input string nm, input [4:0] a, input [11:0] m, input [11:0] e);
    reg [31:0] d;
    begin
      axi_rd(a, d);
      chk(nm, e, d[11:0] & m);
    end
  endtask
  // Waits until the receiver has finished the character on the line
  task automatic tx(input [8:0] c, input nine, input ok, input integer gap);
    reg [31:0] d;
    integer    n;
    begin
      asre_tx_model_i.send(c, nine, ok, gap);
      n = 0;
      d = 32'h0000_0010;
      while (d[4] && n < 60) begin
        axi_rd(`ASRE_OFF_STAT, d);
        n = n + 1;
      end
      chk("rx_idle", 12'h000, d[11:0] & 12'h010);
    end
  endtask
  task automatic t_regs;
    begin
      chk_rd("ctrl_rst", `ASRE_OFF_CTRL, 12'hFFF, 12'h000);
      chk_rd("baud_rst", `ASRE_OFF_BAUD, 12'hFFF, 12'h000);
      chk_rd("ien_rst", `ASRE_OFF_IEN, 12'hFFF, 12'h000);
      chk_rd("stat_rst", `ASRE_OFF_STAT, 12'hFFF, 12'h000);
      chk_rd("unmapped", 5'h1C, 12'hFFF, 12'h000);
      axi_wr(5'h1C, 12'h0FF);
      axi_wr(`ASRE_OFF_BAUD, 12'h001);
      chk_rd("baud", `ASRE_OFF_BAUD, 12'hFFF, 12'h001);
      chk_rd("iclr_rd", `ASRE_OFF_ICLR, 12'hFFF, 12'h000);
    end
  endtask
  task automatic t_frame;
    begin
      axi_wr(`ASRE_OFF_CTRL, 12'h001);
      axi_wr(`ASRE_OFF_CTRL, 12'h003);
      tx(9'h05A, 1'b0, 1'b1, 0);
      tx(9'h0A5, 1'b0, 1'b0, 0);
      chk("irq_masked", 12'h000, {11'h000, irq});
      chk_rd("istat", `ASRE_OFF_ISTAT, 12'h003, 12'h001);
      axi_wr(`ASRE_OFF_IEN, 12'h001);
      chk("irq_on", 12'h001, {11'h000, irq});
      chk_rd("stat1", `ASRE_OFF_STAT, 12'h00F, 12'h008);
      chk_rd("data1", `ASRE_OFF_DATA, 12'h0FF, 12'h05A);
      chk_rd("stat2", `ASRE_OFF_STAT, 12'h00F, 12'h009);
      chk_rd("data2", `ASRE_OFF_DATA, 12'h0FF, 12'h0A5);
      chk_rd("empty", `ASRE_OFF_STAT, 12'h00A, 12'h000);
      axi_wr(`ASRE_OFF_ICLR, 12'h001);
      chk("irq_off", 12'h000, {11'h000, irq});
    end
  endtask
  task automatic t_overrun;
    begin
      tx(9'h011, 1'b0, 1'b1, 0);
      tx(9'h022, 1'b0, 1'b0, 0);
      tx(9'h033, 1'b0, 1'b1, 40);
      chk_rd("ovr", `ASRE_OFF_STAT, 12'h00F, 12'h00A);
      chk_rd("ovr_ev", `ASRE_OFF_ISTAT, 12'h003, 12'h003);
      tx(9'h044, 1'b0, 1'b1, 0);
      chk_rd("o_data1", `ASRE_OFF_DATA, 12'h0FF, 12'h011);
      chk_rd("o_stat", `ASRE_OFF_STAT, 12'h00F, 12'h00B);
      axi_wr(`ASRE_OFF_CTRL, 12'h001);
      chk_rd("o_clr", `ASRE_OFF_STAT, 12'h00F, 12'h009);
      chk_rd("o_data2", `ASRE_OFF_DATA, 12'h0FF, 12'h022);
      chk_rd("o_drop", `ASRE_OFF_STAT, 12'h00A, 12'h000);
      axi_wr(`ASRE_OFF_CTRL, 12'h003);
      tx(9'h055, 1'b0, 1'b0, 0);
      axi_wr(`ASRE_OFF_CTRL, 12'h000);
      chk_rd("u_stat", `ASRE_OFF_STAT, 12'h01F, 12'h000);
      chk_rd("u_istat", `ASRE_OFF_ISTAT, 12'h003, 12'h000);
    end
  endtask
  task automatic t_nine;
    begin
      axi_wr(`ASRE_OFF_CTRL, 12'h007);
      tx(9'h133, 1'b1, 1'b1, 40);
      chk_rd("n_stat1", `ASRE_OFF_STAT, 12'h00F, 12'h00C);
      chk_rd("n_data1", `ASRE_OFF_DATA, 12'h0FF, 12'h033);
      tx(9'h0CC, 1'b1, 1'b1, 0);
      chk_rd("n_stat2", `ASRE_OFF_STAT, 12'h00F, 12'h008);
      chk_rd("n_data2", `ASRE_OFF_DATA, 12'h0FF, 12'h0CC);
      axi_wr(`ASRE_OFF_CTRL, 12'h00F);
      tx(9'h044, 1'b1, 1'b1, 0);
      tx(9'h155, 1'b1, 1'b1, 0);
      chk_rd("a_stat", `ASRE_OFF_STAT, 12'h00F, 12'h00C);
      chk_rd("a_data", `ASRE_OFF_DATA, 12'h0FF, 12'h055);
      chk_rd("a_only", `ASRE_OFF_STAT, 12'h00A, 12'h000);
      axi_wr(`ASRE_OFF_CTRL, 12'h007);
      tx(9'h066, 1'b1, 1'b1, 0);
      chk_rd("m_stat", `ASRE_OFF_STAT, 12'h00F, 12'h008);
      chk_rd("m_data", `ASRE_OFF_DATA, 12'h0FF, 12'h066);
      axi_wr(`ASRE_OFF_CTRL, 12'h00F);
      axi_wr(`ASRE_OFF_ICLR, 12'h003);
      tx(9'h077, 1'b1, 1'b1, 0);
      chk_rd("f_istat", `ASRE_OFF_ISTAT, 12'h003, 12'h000);
      chk_rd("f_stat", `ASRE_OFF_STAT, 12'h00A, 12'h000);
    end
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_frame;
    t_overrun;
    t_nine;
    give_verdict;
  end
  // Whole run needs about 5000 clocks
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule // testbench

// ---- bench/asre_tx_model.sv ----
// Purpose: Remote transmitter on the serial line
// Assumes: Line idles high; the model drives it high outside frames
// Notes:   Stop bit may be sent low to provoke a framing error
`timescale 1ns/1ps
module asre_tx_model #(
  parameter BIT_CLKS = 32
) (
  input  wire aclk, // Bit timing clock
  output reg  line  // Serial line
);
  initial line = 1'b1;
  task automatic send(input [8:0] c, input nine, input ok, input integer gap);
    reg [10:0] f;
    integer    i;
    begin
      f = nine ? {ok, c, 1'b0} : {1'b1, ok, c[7:0], 1'b0};
      repeat (gap) @(posedge aclk);
      for (i = 0; i < (nine ? 11 : 10); i = i + 1) begin
        @(posedge aclk);
        line <= f[i];
        repeat (BIT_CLKS - 1) @(posedge aclk);
      end
      @(posedge aclk);
      line <= 1'b1;
    end
  endtask
endmodule // asre_tx_model

// ---- rtl/asre_fifo.v ----
// Purpose: Two-entry receive FIFO; each entry holds nine data bits and a framing status
// Assumes: Caller never pushes while full and never pops while empty
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ps
module asre_fifo (
  input  wire        aclk,    // System clock
  input  wire        flush,   // Synchronous empty, active high
  input  wire        push,    // Write one entry
  input  wire [9:0]  din,     // {framing error, nine data bits}
  input  wire        pop,     // Drop oldest entry
  output wire [9:0]  head,    // Oldest entry
  output wire        empty,   // No entry held
  output wire        full     // Two entries held
);
  reg [9:0] mem_ff [0:1];
  reg       rd_ff;
  reg       wr_ff;
  reg [1:0] cnt_ff;

  assign head  = mem_ff[rd_ff];
  assign empty = (cnt_ff == 2'h0);
  assign full  = (cnt_ff == 2'h2);

  always @(posedge aclk) begin
    if (flush) begin
      rd_ff  <= 1'b0;
      wr_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= din;
        wr_ff         <= ~wr_ff;
      end
      if (pop)
        rd_ff <= ~rd_ff;
      if (push && !pop)
        cnt_ff <= cnt_ff + 2'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 2'h1;
    end
  end
endmodule // asre_fifo

// ---- rtl/asre_map.vh ----
// Purpose: Register map, field positions, reset values and timing counts of the receiver
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef ASRE_MAP_VH
`define ASRE_MAP_VH

`define ASRE_ADDR_W      5
`define ASRE_OFF_CTRL    5'h00
`define ASRE_OFF_STAT    5'h04
`define ASRE_OFF_DATA    5'h08
`define ASRE_OFF_BAUD    5'h0C
`define ASRE_OFF_ISTAT   5'h10
`define ASRE_OFF_ICLR    5'h14
`define ASRE_OFF_IEN     5'h18

`define ASRE_CTRL_SERIAL_PORT_ENABLE   0
`define ASRE_CTRL_CONTINUOUS_RECEIVE_ENABLE   1
`define ASRE_CTRL_NINE   2
`define ASRE_CTRL_ADDRESS_DETECT_ENABLE  3
`define ASRE_CTRL_CLKM   4
`define ASRE_CTRL_RST    5'h0_0

`define ASRE_STAT_FRAMING_ERROR_FLAG   0
`define ASRE_STAT_OVERRUN_ERROR_FLAG   1
`define ASRE_STAT_BIT9   2
`define ASRE_STAT_RXF    3
`define ASRE_STAT_BUSY   4

`define ASRE_IRQ_RX      0
`define ASRE_IRQ_OVR     1
`define ASRE_IRQ_RST     2'h0

`define ASRE_BAUD_RST    16'h0000
`define ASRE_OVS_LAST    4'hF
`define ASRE_OVS_MID     4'h7

`define ASRE_RESP_OKAY   2'h0
`define ASRE_RESP_SLVERR 2'h2

`endif

// ---- rtl/asre_rx_core.v ----
// Purpose: Asynchronous character receiver with 16x oversampling
// Assumes: Line idles high; one start bit, 8 or 9 data bits LSB first, one stop bit
// Notes:   One oversample tick every divisor+1 clocks
`timescale 1ns/1ps
`include "asre_map.vh"
module asre_rx_core (
  input  wire        aclk,     // System clock
  input  wire        clr,      // Synchronous unit reset
  input  wire        run,      // Receiver enabled
  input  wire        rx_pin,   // Serial line, asynchronous
  input  wire [15:0] divisor,  // Oversample period minus one
  input  wire        nine,     // Nine data bits per character
  output reg         done_ff,  // One-cycle pulse at stop bit sample
  output wire [8:0]  data,     // Character, valid with done
  output reg         framing_error_flag_ff,  // Stop bit low, valid with done
  output wire        busy      // Character in progress
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA  = 2'h2;
  localparam ST_STOP  = 2'h3;

  reg [2:0]  sync_ff;
  reg        line_ff;
  reg        last_ff;
  reg [15:0] div_ff;
  reg [3:0]  ovs_ff;
  reg [3:0]  idx_ff;
  reg [8:0]  sh_ff;
  reg [1:0]  st_ff;
  reg [1:0]  nxt_st;
  wire       tick = (div_ff == divisor);

  assign data = nine ? sh_ff : {1'b0, sh_ff[8:1]};
  assign busy = (st_ff != ST_IDLE);

  // Level changes only once the last two stages agree
  always @(posedge aclk) begin
    if (clr) begin
      sync_ff <= 3'h7;
      line_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], rx_pin};
      last_ff <= line_ff;
      if (sync_ff[1] == sync_ff[2])
        line_ff <= sync_ff[2];
    end
  end

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      // Falling edge only: a low stop bit must not start a false frame
      ST_IDLE:  if (run && last_ff && !line_ff) nxt_st = ST_START;
      ST_START: if (tick && ovs_ff == `ASRE_OVS_MID) nxt_st = line_ff ? ST_IDLE : ST_DATA;
      ST_DATA:  if (tick && ovs_ff == `ASRE_OVS_LAST &&
                    idx_ff == (nine ? 4'h8 : 4'h7)) nxt_st = ST_STOP;
      ST_STOP:  if (tick && ovs_ff == `ASRE_OVS_LAST) nxt_st = ST_IDLE;
      default:  nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (clr) begin
      st_ff   <= ST_IDLE;
      div_ff  <= 16'h0000;
      ovs_ff  <= 4'h0;
      idx_ff  <= 4'h0;
      sh_ff   <= 9'h000;
      done_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      done_ff <= 1'b0;
      div_ff  <= (tick || st_ff == ST_IDLE) ? 16'h0000 : div_ff + 16'h0001;
      if (st_ff == ST_IDLE || (st_ff == ST_START && nxt_st == ST_DATA)) begin
        ovs_ff <= 4'h0;
        idx_ff <= 4'h0;
      end else if (tick) begin
        ovs_ff <= ovs_ff + 4'h1;
        if (st_ff == ST_DATA && ovs_ff == `ASRE_OVS_LAST) begin
          sh_ff  <= {line_ff, sh_ff[8:1]};
          idx_ff <= idx_ff + 4'h1;
        end
        if (st_ff == ST_STOP && ovs_ff == `ASRE_OVS_LAST) begin
          done_ff <= 1'b1;
          framing_error_flag_ff <= ~line_ff;
        end
      end
    end
  end
endmodule // asre_rx_core

// ---- rtl/asre_top.v ----
// Purpose: Serial receiver with two-character FIFO, error status and AXI4-Lite registers
// Assumes: Single clock aclk; aresetn synchronous, active low
// Notes:   Reading the data register pops the FIFO; read status first
// Overview of operation
// - Each held character keeps its own framing status, set when its stop bit was low.
// - The framing flag shows the oldest unread character and follows the FIFO on a data read.
// - The framing flag is read only, needs no clearing and never stops reception.
// - Clearing the port enable resets the unit and the framing flag; clearing receive enable does not.
// - A framing error alone raises no interrupt; only a transfer into the FIFO or an overrun does.
// - The FIFO holds two characters; a third completed character sets the overrun flag.
// - During overrun held characters stay readable and no new character is accepted.
// - Clearing receive enable or port enable clears the overrun flag.
// - With nine-bit select set, nine data bits are shifted in per character.
// - The ninth-bit status shows bit 8 of the oldest unread character.
// - With address detect and nine-bit mode, only characters with bit 8 set are kept.
// - Each transfer into the FIFO sets the receive flag; interrupt only when enabled.
`timescale 1ns/1ps
`include "asre_map.vh"
module asre_top (
  input  wire        aclk,           // System clock, 10 MHz
  input  wire        aresetn,        // Synchronous reset, active low
  input  wire        rx_pin,         // Serial receive line
  output wire        irq,            // Level interrupt
  input  wire [4:0]  s_axi_awaddr,   // Write address
  input  wire        s_axi_awvalid,  // Write address valid
  output wire        s_axi_awready,  // Write address ready
  input  wire [31:0] s_axi_wdata,    // Write data
  input  wire [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire        s_axi_wvalid,   // Write data valid
  output wire        s_axi_wready,   // Write data ready
  output reg  [1:0]  s_axi_bresp,    // Write response
  output reg         s_axi_bvalid,   // Write response valid
  input  wire        s_axi_bready,   // Write response ready
  input  wire [4:0]  s_axi_araddr,   // Read address
  input  wire        s_axi_arvalid,  // Read address valid
  output wire        s_axi_arready,  // Read address ready
  output reg  [31:0] s_axi_rdata,    // Read data
  output reg  [1:0]  s_axi_rresp,    // Read response
  output reg         s_axi_rvalid,   // Read data valid
  input  wire        s_axi_rready    // Read data ready
);
  reg  [4:0]  ctrl_ff;
  reg  [15:0] baud_ff;
  reg         overrun_error_flag_ff;
  reg  [1:0]  ists_ff;
  reg  [1:0]  ien_ff;
  reg         aw_got_ff;
  reg  [4:0]  aw_addr_ff;
  reg         w_got_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;

  wire        serial_port_enable  = ctrl_ff[`ASRE_CTRL_SERIAL_PORT_ENABLE];
  wire        continuous_receive_enable  = ctrl_ff[`ASRE_CTRL_CONTINUOUS_RECEIVE_ENABLE];
  wire        nine  = ctrl_ff[`ASRE_CTRL_NINE];
  wire        address_detect_enable = ctrl_ff[`ASRE_CTRL_ADDRESS_DETECT_ENABLE];
  wire        clkm  = ctrl_ff[`ASRE_CTRL_CLKM];
  wire        unit_clr = !aresetn || !serial_port_enable;

  wire        rx_done;
  wire [8:0]  rx_data;
  wire        rx_framing_error_flag;
  wire        rx_busy;
  wire [9:0]  fifo_head;
  wire        fifo_empty;
  wire        fifo_full;

  // Word-aligned register match
  function sel;
    input [4:0] addr;
    input [4:0] off;
    begin
      sel = (addr[4:2] == off[4:2]);
    end
  endfunction

  function mapped;
    input [4:0] addr;
    begin
      mapped = (addr[4:2] <= `ASRE_OFF_IEN >> 2);
    end
  endfunction

  // Byte-lane merge for writable registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  asre_rx_core u_core (
    .aclk    (aclk),
    .clr     (unit_clr),
    .run     (continuous_receive_enable && !clkm),
    .rx_pin  (rx_pin),
    .divisor (baud_ff),
    .nine    (nine),
    .done_ff (rx_done),
    .data    (rx_data),
    .framing_error_flag_ff (rx_framing_error_flag),
    .busy    (rx_busy)
  );

  // Address filter works only with nine-bit reception active
  wire keep = !(address_detect_enable && nine && !rx_data[8]);
  // An overrun holds off all further characters until cleared
  wire accept   = rx_done && keep && !overrun_error_flag_ff;
  wire push     = accept && !fifo_full;
  wire ovr_set  = accept && fifo_full;

  // Write path: address and data taken in either order
  wire wr_fire  = aw_got_ff && w_got_ff && !s_axi_bvalid;
  wire wr_ok    = mapped(aw_addr_ff);
  wire [31:0] wr_ctrl = merge({27'h0, ctrl_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_baud = merge({16'h0, baud_ff}, w_data_ff, w_strb_ff);
  wire wr_ctrl_en = wr_fire && sel(aw_addr_ff, `ASRE_OFF_CTRL);
  wire continuous_receive_enable_drop  = wr_ctrl_en && !wr_ctrl[`ASRE_CTRL_CONTINUOUS_RECEIVE_ENABLE];
  wire serial_port_enable_drop  = wr_ctrl_en && !wr_ctrl[`ASRE_CTRL_SERIAL_PORT_ENABLE];
  wire [1:0] iclr = (wr_fire && sel(aw_addr_ff, `ASRE_OFF_ICLR) && w_strb_ff[0]) ?
                    w_data_ff[1:0] : 2'h0;

  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;

  // Read path
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;
  wire pop = rd_fire && sel(s_axi_araddr, `ASRE_OFF_DATA) && !fifo_empty;

  asre_fifo u_fifo (
    .aclk  (aclk),
    .flush (unit_clr),
    .push  (push),
    .din   ({rx_framing_error_flag, rx_data}),
    .pop   (pop),
    .head  (fifo_head),
    .empty (fifo_empty),
    .full  (fifo_full)
  );

  wire [4:0] stat = {rx_busy, !fifo_empty,
                     fifo_head[8],
                     overrun_error_flag_ff,
                     fifo_head[9] && !fifo_empty};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff    <= 1'b0;
      aw_addr_ff   <= 5'h00;
      w_got_ff     <= 1'b0;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ASRE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `ASRE_RESP_OKAY : `ASRE_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `ASRE_CTRL_RST;
      baud_ff <= `ASRE_BAUD_RST;
      ien_ff  <= `ASRE_IRQ_RST;
    end else if (wr_fire) begin
      if (sel(aw_addr_ff, `ASRE_OFF_CTRL))
        ctrl_ff <= wr_ctrl[4:0];
      if (sel(aw_addr_ff, `ASRE_OFF_BAUD))
        baud_ff <= wr_baud[15:0];
      if (sel(aw_addr_ff, `ASRE_OFF_IEN) && w_strb_ff[0])
        ien_ff <= w_data_ff[1:0];
    end
  end

  // Overrun: cleared by dropping either enable; a new overrun in that cycle wins
  always @(posedge aclk) begin
    if (unit_clr)
      overrun_error_flag_ff <= 1'b0;
    else if (ovr_set)
      overrun_error_flag_ff <= 1'b1;
    else if (!continuous_receive_enable || continuous_receive_enable_drop || serial_port_enable_drop)
      overrun_error_flag_ff <= 1'b0;
  end

  // Sticky events; set wins over a simultaneous clear. Framing errors are not events.
  always @(posedge aclk) begin
    if (unit_clr) begin
      ists_ff <= `ASRE_IRQ_RST;
    end else begin
      ists_ff[`ASRE_IRQ_RX]  <= push || (ists_ff[`ASRE_IRQ_RX] && !iclr[`ASRE_IRQ_RX]);
      ists_ff[`ASRE_IRQ_OVR] <= ovr_set || (ists_ff[`ASRE_IRQ_OVR] && !iclr[`ASRE_IRQ_OVR]);
    end
  end

  assign irq = |(ists_ff & ien_ff);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ASRE_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `ASRE_RESP_OKAY : `ASRE_RESP_SLVERR;
      s_axi_rdata  <= 32'h0000_0000;
      if (sel(s_axi_araddr, `ASRE_OFF_CTRL))
        s_axi_rdata <= {27'h0, ctrl_ff};
      if (sel(s_axi_araddr, `ASRE_OFF_STAT))
        s_axi_rdata <= {27'h0, stat};
      if (sel(s_axi_araddr, `ASRE_OFF_DATA) && !fifo_empty)
        s_axi_rdata <= {24'h0, fifo_head[7:0]};
      if (sel(s_axi_araddr, `ASRE_OFF_BAUD))
        s_axi_rdata <= {16'h0, baud_ff};
      if (sel(s_axi_araddr, `ASRE_OFF_ISTAT))
        s_axi_rdata <= {30'h0, ists_ff};
      if (sel(s_axi_araddr, `ASRE_OFF_IEN))
        s_axi_rdata <= {30'h0, ien_ff};
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // asre_top
